// ==== design/ptb_xfer_ctrl.sv ====
// Backend transfer control for a PCI target: wide data, half-rate reads, terminations
// Operation
// - Wide mode: 64-bit data, eight strobes
// - Wide mode address steps by eight
// - No narrow-slot fallback logic needed
// - Half-rate read: two or three clocks
// - Half-rate read: master wait adds cycles between reads
// - Half-rate option leaves writes full speed
// - Busy at start gives retry
// - No backend answer in eight: stop
// - Error input gives target abort
// - Busy mid-burst gives disconnect
// - Stop withheld until pipe drained
// - Read data still accepted after busy
// - Busy held: later cycles retried
// - Accepted write words written before stop
// - Write strobes all lanes set
`timescale 1ns/1ps
`default_nettype none
module ptb_xfer_ctrl #(
    parameter bit WIDE_MODE = 1'b1,  // 64-bit build
    parameter bit SLOW_READ = 1'b0,  // half-rate read option
    parameter bit RD_STAGE  = 1'b0,  // extra read stage
    parameter int AW        = 16     // backend address width
) (
    input  wire logic           sys_clk,                  // clock
    input  wire logic           rst_n,                    // sync reset, low
    // PCI side
    input  wire logic           pciStart,                 // target cycle claimed, pulse
    input  wire logic           pciRead,                  // cycle is a read
    input  wire logic           pciFrameEnd,              // master ended burst, pulse
    input  wire logic [AW-1:0]  pciAddr,                  // start address
    input  wire logic           irdyN,                    // master ready, low
    input  wire logic [63:0]    pciWrData,                // write word from bus
    input  wire logic           pciWrValid,               // write word present
    output logic                pciWrReady,               // write word taken
    output logic [63:0]         pciRdData,                // read word to bus
    output logic                pciRdValid,               // read word present (trdy)
    input  wire logic           pciRdReady,               // read word taken by master
    output logic                stopN,                    // stop request, low
    output logic [1:0]          termKind,                 // retry/disconnect/abort code
    // Backend side
    output logic                backend_cycle_begin_pulse,// cycle begins
    output logic                backend_cycle_end_pulse,  // cycle ends
    output logic                wide_transfer_flag,       // 64-bit cycle
    output logic                rdCycle,                  // read cycle active
    output logic                wrCycle,                  // write cycle active
    output logic [AW-1:0]       memAddr,                  // backend address
    output logic                rdStrobe,                 // read request
    output logic [7:0]          readByteStrobes,          // read byte lanes
    input  wire logic           backend_read_valid,       // read word valid
    input  wire logic [63:0]    memRdData,                // backend read word
    input  wire logic           backend_write_accept,     // backend takes writes
    output logic [7:0]          write_byte_lane_strobes,  // write lanes, nonzero = write
    output logic [63:0]         memWrData,                // backend write word
    input  wire logic           busy,                     // backend busy
    input  wire logic           error                     // backend error
);
    // ======================================================================
    // State
    // ======================================================================
    localparam logic [7:0] LANES = WIDE_MODE ? 8'hff : 8'h0f;
    localparam logic [3:0] STEP  = WIDE_MODE ? ptb_pkg::ADDR_STEP_WIDE : ptb_pkg::ADDR_STEP_NARROW;

    typedef struct packed {
        ptb_pkg::ptb_state_e fsm;
        logic                isRead;
        logic [AW-1:0]       addr;
        logic [3:0]          wait8;
        logic                gotData;
        logic                beginP;
        logic                endP;
        logic [1:0]          term;
        logic [7:0]          wrLanes;
        logic [63:0]         wrData;
        logic [63:0]         rdData;
        logic                rdFull;
    } ptb_ctrl_s;
    ptb_ctrl_s st;
    ptb_ctrl_s next_st;

    logic        bufInReady;
    logic        bufOutValid;
    logic [63:0] bufOutData;
    logic        bufPush;
    logic        bufClr;
    logic        paceAllow;
    logic        rdFire;
    logic        active;
    logic        endNow;

    // ======================================================================
    // Read path: pacing and two-entry buffer
    // ======================================================================
    assign active  = (st.fsm == ptb_pkg::PTB_XFER) || (st.fsm == ptb_pkg::PTB_DRAIN);
    // Reads keep flowing in drain while valid is held
    assign rdFire  = active && st.isRead && backend_read_valid && bufInReady && paceAllow;
    assign bufPush = rdFire;
    assign bufClr  = endNow;

    ptb_pace u_pace (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .enable    (SLOW_READ),
        .syncStage (RD_STAGE),
        .fire      (rdFire),
        .hold      (irdyN),
        .allow     (paceAllow)
    );

    ptb_skid_buf #(.WIDTH(64)) u_buf (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .clr      (bufClr),
        .inData   (memRdData),
        .inValid  (bufPush),
        .inReady  (bufInReady),
        .outData  (bufOutData),
        .outValid (bufOutValid),
        .outReady (pciRdReady)
    );

    // Stall on master back-pressure is the buffer filling
    assign pciRdValid = active && st.isRead && bufOutValid;
    assign pciRdData  = bufOutData;
    assign rdStrobe   = rdFire;

    // Writes go one per clock whatever the read option
    assign pciWrReady = (st.fsm == ptb_pkg::PTB_XFER) && !st.isRead && backend_write_accept && !busy;

    // Cycle closes on frame end with empty pipe, or after stop
    assign endNow = (st.fsm == ptb_pkg::PTB_STOP || st.fsm == ptb_pkg::PTB_ABORT) && pciFrameEnd
                 || (st.fsm == ptb_pkg::PTB_XFER && pciFrameEnd && !bufOutValid);

    // ======================================================================
    // Control machine
    // ======================================================================
    always_comb begin
        next_st        = st;
        next_st.beginP = 1'b0;
        next_st.endP   = 1'b0;
        next_st.wrLanes = 8'h00;
        unique case (st.fsm)
            ptb_pkg::PTB_IDLE: begin
                if (pciStart) begin
                    next_st.beginP  = 1'b1;
                    next_st.isRead  = pciRead;
                    next_st.addr    = pciAddr;
                    next_st.wait8   = 4'h0;
                    next_st.gotData = 1'b0;
                    next_st.term    = ptb_pkg::PTB_TERM_NONE;
                    if (error) begin
                        next_st.fsm  = ptb_pkg::PTB_ABORT;
                        next_st.term = ptb_pkg::PTB_TERM_ABORT;
                    end else if (busy) begin
                        // Busy left high retries every new cycle
                        next_st.fsm  = ptb_pkg::PTB_STOP;
                        next_st.term = ptb_pkg::PTB_TERM_RETRY;
                    end else begin
                        next_st.fsm = ptb_pkg::PTB_XFER;
                    end
                end
            end
            ptb_pkg::PTB_XFER: begin
                if (error) begin
                    next_st.fsm  = ptb_pkg::PTB_ABORT;
                    next_st.term = ptb_pkg::PTB_TERM_ABORT;
                end else if (busy) begin
                    next_st.fsm  = ptb_pkg::PTB_DRAIN;
                    next_st.term = st.gotData ? ptb_pkg::PTB_TERM_DISC : ptb_pkg::PTB_TERM_RETRY;
                end else if (st.wait8 == 4'(ptb_pkg::STALL_LIMIT_CLKS - 1)
                             && !(rdFire || (pciWrValid && pciWrReady))) begin
                    next_st.fsm  = ptb_pkg::PTB_DRAIN;
                    next_st.term = st.gotData ? ptb_pkg::PTB_TERM_DISC : ptb_pkg::PTB_TERM_RETRY;
                end
                if (pciFrameEnd && !bufOutValid) begin
                    next_st.fsm = ptb_pkg::PTB_IDLE;
                    next_st.endP = 1'b1;
                end
            end
            ptb_pkg::PTB_DRAIN: begin
                // Stop waits for buffered words to reach the bus
                if (!bufOutValid && !(backend_read_valid && st.isRead)) begin
                    next_st.fsm = ptb_pkg::PTB_STOP;
                end
                if (error) begin
                    next_st.fsm  = ptb_pkg::PTB_ABORT;
                    next_st.term = ptb_pkg::PTB_TERM_ABORT;
                end
            end
            ptb_pkg::PTB_STOP, ptb_pkg::PTB_ABORT: begin
                if (pciFrameEnd) begin
                    next_st.fsm  = ptb_pkg::PTB_IDLE;
                    next_st.endP = 1'b1;
                end
            end
            default: begin
                next_st.fsm = ptb_pkg::PTB_IDLE;
            end
        endcase

        // Timeout counter restarts on every read word taken into the buffer or write word taken
        if (active) begin
            if (rdFire || (pciWrValid && pciWrReady)) begin
                next_st.wait8   = 4'h0;
                next_st.gotData = 1'b1;
            end else if (st.wait8 != 4'(ptb_pkg::STALL_LIMIT_CLKS - 1)) begin
                next_st.wait8 = st.wait8 + 4'h1;
            end
        end

        // Address steps by four or eight per word; writes step after the strobe cycle
        // so that address, data and lanes reach the backend together
        if (rdFire || st.wrLanes != 8'h00) begin
            next_st.addr = st.addr + AW'(STEP);
        end

        // Taken write words always reach the backend
        if (pciWrValid && pciWrReady) begin
            next_st.wrLanes = LANES;
            next_st.wrData  = WIDE_MODE ? pciWrData : {32'h0, pciWrData[31:0]};
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    // Narrow-slot fallback omitted: wide builds assume a wide bus
    assign wide_transfer_flag        = WIDE_MODE && (st.fsm != ptb_pkg::PTB_IDLE);
    assign backend_cycle_begin_pulse = st.beginP;
    assign backend_cycle_end_pulse   = st.endP;
    assign rdCycle                   = (st.fsm != ptb_pkg::PTB_IDLE) && st.isRead;
    assign wrCycle                   = (st.fsm != ptb_pkg::PTB_IDLE) && !st.isRead;
    assign memAddr                   = st.addr;
    assign readByteStrobes           = LANES;
    assign write_byte_lane_strobes   = st.wrLanes;
    assign memWrData                 = st.wrData;
    assign stopN                     = !(st.fsm == ptb_pkg::PTB_STOP || st.fsm == ptb_pkg::PTB_ABORT);
    assign termKind                  = st.term;

    // ======================================================================
    // Checks
    // ======================================================================
    property p_retry_on_busy;
        @(posedge sys_clk) disable iff (!rst_n)
        (st.fsm == ptb_pkg::PTB_IDLE && pciStart && busy && !error) |=> (!stopN && termKind == 2'b01);
    endproperty
    a_retry_on_busy: assert property (p_retry_on_busy) else $error("busy at start not retried");

    property p_abort;
        @(posedge sys_clk) disable iff (!rst_n)
        (st.fsm == ptb_pkg::PTB_IDLE && pciStart && error) |=> (!stopN && termKind == 2'b11);
    endproperty
    a_abort: assert property (p_abort) else $error("error not aborted");

    property p_addr_step;
        @(posedge sys_clk) disable iff (!rst_n)
        (rdFire && !pciStart) |=> (memAddr == $past(memAddr) + AW'(STEP));
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address step wrong");

    property p_wr_lanes;
        @(posedge sys_clk) disable iff (!rst_n)
        (pciWrValid && pciWrReady) |=> (write_byte_lane_strobes == LANES);
    endproperty
    a_wr_lanes: assert property (p_wr_lanes) else $error("write lanes not all set");

    property p_no_stop_with_data;
        @(posedge sys_clk) disable iff (!rst_n)
        (st.fsm == ptb_pkg::PTB_DRAIN && bufOutValid) |=> stopN;
    endproperty
    a_no_stop_with_data: assert property (p_no_stop_with_data) else $error("stop before drain");

    property p_timeout;
        @(posedge sys_clk) disable iff (!rst_n)
        (st.fsm == ptb_pkg::PTB_XFER && !busy && !error && !pciFrameEnd
         && st.wait8 == 4'(ptb_pkg::STALL_LIMIT_CLKS - 1) && !rdFire && !pciWrReady)
        |=> (st.fsm == ptb_pkg::PTB_DRAIN);
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout stop missing");

    property p_slow_spacing;
        @(posedge sys_clk) disable iff (!rst_n)
        (SLOW_READ && rdFire) |=> !rdFire;
    endproperty
    a_slow_spacing: assert property (p_slow_spacing) else $error("half-rate read too fast");

    property p_begin_end;
        @(posedge sys_clk) disable iff (!rst_n)
        backend_cycle_end_pulse |-> (st.fsm == ptb_pkg::PTB_IDLE && !backend_cycle_begin_pulse);
    endproperty
    a_begin_end: assert property (p_begin_end) else $error("end pulse misplaced");

    property p_wide_flag;
        @(posedge sys_clk) disable iff (!rst_n)
        backend_cycle_begin_pulse |-> (wide_transfer_flag == WIDE_MODE);
    endproperty
    a_wide_flag: assert property (p_wide_flag) else $error("wide flag wrong");
endmodule : ptb_xfer_ctrl
`default_nettype wire

// ==== design/ptb_pkg.sv ====
// Shared constants for the PCI target backend transfer control
package ptb_pkg;
    // ======================================================================
    // Timing
    // ======================================================================
    localparam int unsigned CLK_PERIOD_NS     = 5;
    localparam int unsigned STALL_LIMIT_CLKS  = 8;        // backend answer limit, clocks
    localparam int unsigned SLOW_GAP_NOSYNC   = 2;        // half-rate read spacing
    localparam int unsigned SLOW_GAP_SYNC     = 3;        // with extra read stage
    // ======================================================================
    // Address step
    // ======================================================================
    localparam logic [3:0] ADDR_STEP_WIDE     = 4'h8;
    localparam logic [3:0] ADDR_STEP_NARROW   = 4'h4;
    // ======================================================================
    // States and terminations
    // ======================================================================
    typedef enum logic [2:0] {
        PTB_IDLE    = 3'b000,
        PTB_XFER    = 3'b001,
        PTB_DRAIN   = 3'b010,
        PTB_STOP    = 3'b011,
        PTB_ABORT   = 3'b100
    } ptb_state_e;
    typedef enum logic [1:0] {
        PTB_TERM_NONE  = 2'b00,
        PTB_TERM_RETRY = 2'b01,
        PTB_TERM_DISC  = 2'b10,
        PTB_TERM_ABORT = 2'b11
    } ptb_term_e;
endpackage : ptb_pkg

// ==== design/ptb_skid_buf.sv ====
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ptb_skid_buf #(
    parameter int WIDTH = 72
) (
    input  wire logic             sys_clk,   // clock
    input  wire logic             rst_n,     // sync reset, low
    input  wire logic             clr,       // flush entries
    input  wire logic [WIDTH-1:0] inData,    // word in
    input  wire logic             inValid,   // word offered
    output logic                  inReady,   // room left
    output logic [WIDTH-1:0]      outData,   // head word
    output logic                  outValid,  // head valid
    input  wire logic             outReady   // head taken
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  wp;
        logic                  rp;
        logic [1:0]            cnt;
    } ptb_buf_s;
    ptb_buf_s st;
    ptb_buf_s next_st;
    logic     push;
    logic     pop;

    // ======================================================================
    // Handshake
    // ======================================================================
    assign inReady  = (st.cnt != 2'h2);
    assign outValid = (st.cnt != 2'h0);
    assign outData  = st.mem[st.rp];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // Pointer update; flush beats any push
    always_comb begin
        next_st = st;
        if (clr) begin
            next_st.wp  = 1'b0;
            next_st.rp  = 1'b0;
            next_st.cnt = 2'h0;
        end else begin
            if (push) begin
                next_st.mem[st.wp] = inData;
                next_st.wp         = ~st.wp;
            end
            if (pop) begin
                next_st.rp = ~st.rp;
            end
            next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : ptb_skid_buf
`default_nettype wire

// ==== design/ptb_pace.sv ====
// Read pacing counter for the half-rate read option
`timescale 1ns/1ps
`default_nettype none
module ptb_pace (
    input  wire logic sys_clk,   // clock
    input  wire logic rst_n,     // sync reset, low
    input  wire logic enable,    // half-rate reads on
    input  wire logic syncStage, // extra read stage
    input  wire logic fire,      // read word taken
    input  wire logic hold,      // master not ready
    output logic      allow      // next read may go
);
    typedef struct packed {
        logic [1:0] gap;
    } ptb_pace_s;
    ptb_pace_s st;
    ptb_pace_s next_st;
    logic [1:0] gapLoad;

    // Gap minus the taking cycle itself
    assign gapLoad = syncStage ? 2'(ptb_pkg::SLOW_GAP_SYNC - 1) : 2'(ptb_pkg::SLOW_GAP_NOSYNC - 1);
    assign allow   = !enable || (st.gap == 2'h0 && !hold);

    // Countdown freezes while the master waits, adding cycles
    always_comb begin
        next_st = st;
        if (fire && enable) begin
            next_st.gap = gapLoad;
        end else if (st.gap != 2'h0 && !hold) begin
            next_st.gap = st.gap - 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : ptb_pace
`default_nettype wire

// ==== bench/ptb_mem_model.sv ====
// Backend memory model facing the transfer control
`timescale 1ns/1ps
`default_nettype none
module ptb_mem_model (
    input  wire logic        sys_clk,  // Clock
    input  wire logic        rst_n,    // Sync reset, low
    input  wire logic        rdOn,     // Reads offered
    input  wire logic        wrOn,     // Writes accepted
    input  wire logic        busyOn,   // Busy request
    input  wire logic        errOn,    // Error request
    input  wire logic        endPulse, // Cycle end
    input  wire logic [15:0] memAddr,  // Address
    input  wire logic [7:0]  lanes,    // Write lanes
    input  wire logic [63:0] wrData,   // Write word
    output logic             rdValid,  // Read word valid
    output logic [63:0]      rdData,   // Read word
    output logic             wrAccept, // Writes taken
    output logic             busy,     // Busy
    output logic             error     // Error
);
    // ==========================================================
    // Log of written words, read data from address
    logic [15:0] wAddr [8];
    logic [63:0] wData [8];
    logic [7:0]  wLanes [8];
    int          wrCount;
    logic        errHeld;
    logic [31:0] a32;
    // Idle data is inverted so a stale word never looks valid
    assign a32      = {16'h0000, memAddr};
    assign rdData   = rdValid ? {~a32, a32} : {a32, ~a32};
    assign busy     = busyOn;
    assign rdValid  = rdOn && !busyOn;
    assign wrAccept = wrOn;
    assign error    = errOn || errHeld;
    // Error stays up until the cycle end pulse, even if the request drops
    always_ff @(posedge sys_clk) begin
        if (!rst_n || endPulse) begin
            errHeld <= 1'b0;
        end else if (errOn) begin
            errHeld <= 1'b1;
        end
    end
    // Only eight slots: later writes are dropped from the log
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wrCount <= 0;
        end else if (lanes != 8'h00 && wrCount < 8) begin
            wAddr[wrCount]  <= memAddr;
            wData[wrCount]  <= wrData;
            wLanes[wrCount] <= lanes;
            wrCount         <= wrCount + 1;
        end
    end
endmodule : ptb_mem_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Testbench for the backend transfer control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 0, rst_n = 0, pciStart = 0, pciRead = 0, pciFrameEnd = 0;
    logic pciWrValid = 0, pciRdReady = 0, rdOn = 0, wrOn = 0, busyOn = 0, errOn = 0;
    logic [15:0] pciAddr = '0;
    logic [63:0] pciWrData = '0;
    logic pciWrReady, pciRdValid, stopN, beginP, endP, wideF, rdStrobe, rdValid, wrAccept, busy, error;
    logic [1:0] termKind;
    logic [15:0] memAddr;
    logic [7:0] rdLanes, wrLanes;
    logic [63:0] pciRdData, memRdData, memWrData;
    int n_errors = 0, cmp_count = 0, cycles = 0;
    // ==========================================================
    // Design and backend model
    ptb_xfer_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .pciStart(pciStart), .pciRead(pciRead),
        .pciFrameEnd(pciFrameEnd), .pciAddr(pciAddr), .irdyN(1'b0), .pciWrData(pciWrData),
        .pciWrValid(pciWrValid), .pciWrReady(pciWrReady), .pciRdData(pciRdData), .pciRdValid(pciRdValid),
        .pciRdReady(pciRdReady), .stopN(stopN), .termKind(termKind), .backend_cycle_begin_pulse(beginP),
        .backend_cycle_end_pulse(endP), .wide_transfer_flag(wideF), .rdCycle(), .wrCycle(),
        .memAddr(memAddr), .rdStrobe(rdStrobe), .readByteStrobes(rdLanes), .backend_read_valid(rdValid),
        .memRdData(memRdData), .backend_write_accept(wrAccept), .write_byte_lane_strobes(wrLanes),
        .memWrData(memWrData), .busy(busy), .error(error));
    ptb_mem_model i_mem (.sys_clk(sys_clk), .rst_n(rst_n), .rdOn(rdOn), .wrOn(wrOn), .busyOn(busyOn),
        .errOn(errOn), .endPulse(endP), .memAddr(memAddr), .lanes(wrLanes), .wrData(memWrData),
        .rdValid(rdValid), .rdData(memRdData), .wrAccept(wrAccept), .busy(busy), .error(error));
    // ==========================================================
    // Clock and hang guard, well above the roughly 75 cycles needed
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end
    // ==========================================================
    // Shared helpers
    function automatic logic [63:0] pat(input logic [15:0] a);
        return {16'hffff, ~a, 16'h0000, a};
    endfunction : pat
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic start_cyc(input logic rd, input logic [15:0] a);
        @(posedge sys_clk);
        pciStart <= 1'b1;
        pciRead  <= rd;
        pciAddr  <= a;
        @(posedge sys_clk);
        pciStart <= 1'b0;
        @(negedge sys_clk);
        chk(beginP, 1'b1, "begin pulse");
        chk(wideF, 1'b1, "wide flag");
    endtask : start_cyc
    task automatic wait_stop(input logic [1:0] kind, output int n);
        n = 0;
        while (stopN !== 1'b0 && n < 14) begin
            @(negedge sys_clk);
            n++;
        end
        chk(stopN, 1'b0, "stop");
        chk(termKind, kind, "term kind");
    endtask : wait_stop
    task automatic end_cyc(input string name);
        int n;
        @(posedge sys_clk);
        pciFrameEnd <= 1'b1;
        @(posedge sys_clk);
        pciFrameEnd <= 1'b0;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (endP !== 1'b1 && n < 8);
        chk(endP, 1'b1, "end pulse");
        @(negedge sys_clk);
        chk(wideF, 1'b0, "wide flag idle");
        chk(stopN, 1'b1, "stop released");
        $display("%s finished", name);
    endtask : end_cyc
    // ==========================================================
    // Scenarios
    task automatic t_read();
        logic [63:0] got [4];
        int k, n, s;
        rdOn <= 1'b1;
        start_cyc(1'b1, 16'h0100);
        s = rdStrobe;
        repeat (6) begin
            @(negedge sys_clk);
            s += rdStrobe;
        end
        chk(s, 2, "stalled buffer fill");
        chk(rdLanes, 8'hff, "read lanes");
        @(posedge sys_clk);
        pciRdReady <= 1'b1;
        k = 0;
        n = 0;
        while (k < 4 && n < 20) begin
            @(negedge sys_clk);
            if (pciRdValid === 1'b1) begin
                got[k] = pciRdData;
                k++;
            end
            n++;
        end
        rdOn <= 1'b0;
        for (int i = 0; i < 4; i++) chk(got[i], pat(16'h0100 + 16'(8 * i)), "read word");
        end_cyc("wide read");
    endtask : t_read
    task automatic t_write_busy();
        int k, n;
        logic tk;
        wrOn <= 1'b1;
        start_cyc(1'b0, 16'h0200);
        @(posedge sys_clk);
        pciWrValid <= 1'b1;
        pciWrData  <= pat(16'h0000);
        k = 0;
        n = 0;
        while (k < 3 && n < 20) begin
            @(negedge sys_clk);
            tk = pciWrValid && pciWrReady;
            @(posedge sys_clk);
            if (tk) begin
                k++;
                pciWrData <= pat(16'(k));
            end
            n++;
        end
        busyOn <= 1'b1;
        wait_stop(2'd2, n);
        chk(i_mem.wrCount, 3, "words written before stop");
        @(posedge sys_clk);
        pciWrValid <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            chk(i_mem.wData[i], pat(16'(i)), "write word");
            chk(i_mem.wLanes[i], 8'hff, "write lanes");
        end
        chk(i_mem.wAddr[0], 16'h0200, "first write address");
        chk(i_mem.wAddr[2] - i_mem.wAddr[1], 16'h0008, "write step");
        end_cyc("write with busy");
    endtask : t_write_busy
    task automatic t_busy_held();
        int n;
        start_cyc(1'b0, 16'h0300);
        wait_stop(2'd1, n);
        chk(i_mem.wrCount, 3, "no write while busy");
        end_cyc("busy held");
        busyOn <= 1'b0;
        wrOn   <= 1'b0;
    endtask : t_busy_held
    task automatic t_busy_read();
        int n;
        rdOn       <= 1'b1;
        pciRdReady <= 1'b1;
        start_cyc(1'b1, 16'h0400);
        repeat (3) @(posedge sys_clk);
        busyOn <= 1'b1;
        wait_stop(2'd2, n);
        chk(pciRdValid, 1'b0, "pipe drained at stop");
        end_cyc("busy read");
        busyOn <= 1'b0;
        rdOn   <= 1'b0;
    endtask : t_busy_read
    task automatic t_timeout();
        int n;
        start_cyc(1'b1, 16'h0500);
        wait_stop(2'd1, n);
        chk(n inside {[7:10]}, 1'b1, "stall limit");
        end_cyc("timeout");
    endtask : t_timeout
    task automatic t_error();
        int n;
        errOn <= 1'b1;
        start_cyc(1'b1, 16'h0600);
        @(posedge sys_clk);
        errOn <= 1'b0;
        wait_stop(2'd3, n);
        chk(error, 1'b1, "error held");
        end_cyc("error abort");
        chk(error, 1'b0, "error released");
    endtask : t_error
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_read();
        t_write_busy();
        t_busy_held();
        t_busy_read();
        t_timeout();
        t_error();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
